// file: src/mcd_playback_dma.sv
`timescale 1ns/100ps
// Contract
// - Twelve-layer buffer per track, eight tracks, 24-bit samples before the outputs.
// - Each burst fills four layers for every active channel of the stream.
// - Request again while eight or fewer layers hold data; empty buffer takes three requests.
// - Words are 32-bit, sample taken left-justified from the top bits.
// - One request is one burst; default and largest burst is 32 words.
// - Burst code 00/01/10/11 gives 32/24/16/8 words, 8/6/4/2 channels.
// - Tracks freed by smaller bursts serve independent pair DMAs with own requests.
// - I2S uses pair 0 only; packed link maps pairs to slots 3/4,6/9,7/8,10/11.
// - Address register writes base, reads current address; bits 1:0 read zero.
// - 19-bit count takes size minus one, decrements, reloads at zero, reads current.
// - Run register starts or stops each channel; bit 3 reads zero.
// - Pair 3, 2, 1 bits act only for burst code >00, >01, =11.
// - Underrun or overrun sets the channel flag at the run-register bit position.
// - Any set flag raises the interrupt request.
// - Writing 1 clears a flag; writing 0 leaves it alone.
// - Pause register suspends or resumes each channel; bit 3 reads zero.
// - Mask register resets to all ones; bit 3 clear enables the error interrupt.
module mcd_playback_dma (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire mcd_pkg::mcd_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Bus master
  output mcd_pkg::mcd_dma_req_t dma_req,
  input wire logic dma_gnt,
  input wire logic dma_dvalid,
  input wire logic [31:0] dma_data,
  // Serial output side
  input wire logic sample_tick,
  input wire logic aclink_packed,
  input wire logic [2:0] ext_err,
  output mcd_pkg::mcd_slots_t slot_data,
  output logic irq
);
  import mcd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER} mcd_state_t;

  function automatic logic [2:0] pairs_of(input logic [1:0] bs);
    case (bs)
      BS_8CH: pairs_of = 3'd4;
      BS_6CH: pairs_of = 3'd3;
      BS_4CH: pairs_of = 3'd2;
      default: pairs_of = 3'd1;
    endcase
  endfunction

  function automatic int pair_bit(input int p);
    case (p)
      1: pair_bit = BIT_PAIR1;
      2: pair_bit = BIT_PAIR2;
      3: pair_bit = BIT_PAIR3;
      default: pair_bit = BIT_PAIR0;
    endcase
  endfunction

  function automatic logic [3:0] wrap12(input logic [4:0] x);
    wrap12 = (x > {1'b0, LAST_LAYER}) ? 4'(x - 5'd12) : x[3:0];
  endfunction

  function automatic logic [31:0] put_byte(input logic [31:0] old, input logic [1:0] sel, input logic [7:0] d);
    logic [31:0] r;
    r = old;
    r[sel*8 +: 8] = d;
    put_byte = r;
  endfunction

  mcd_state_t state_q, state_d;
  logic [29:0] base_addr_q, cur_addr_q;
  logic [18:0] base_cnt_q, cur_cnt_q;
  logic [7:0] run_q, pause_q, flags_q, mask_q;
  logic [1:0] bs_q;
  logic [3:0] lvl_q [PAIRS];
  logic [3:0] wp_q [PAIRS];
  logic [3:0] rp_q [PAIRS];
  logic [SAMPLE_W-1:0] mem [LAYERS][TRACKS];
  logic [1:0] str_q;
  logic [2:0] trk_q;
  logic [1:0] lay_q;

  // Register decode
  wire wr_addr = reg_req.wr && reg_req.addr >= OFF_ADDR_B0 && reg_req.addr <= OFF_ADDR_B3;
  wire wr_cnt = reg_req.wr && reg_req.addr >= OFF_CNT_B0 && reg_req.addr <= OFF_CNT_B2;
  wire wr_run = reg_req.wr && reg_req.addr == OFF_RUN;
  wire wr_bs = reg_req.wr && reg_req.addr == OFF_BURST;
  wire wr_flags = reg_req.wr && reg_req.addr == OFF_FLAGS;
  wire wr_pause = reg_req.wr && reg_req.addr == OFF_PAUSE;
  wire wr_mask = reg_req.wr && reg_req.addr == OFF_IRQ_MASK;
  wire [1:0] bsel = reg_req.addr[1:0];
  wire [31:0] addr_new = put_byte({base_addr_q, 2'b00}, bsel, reg_req.wdata);
  wire [31:0] cnt_new = put_byte({13'h0, base_cnt_q}, bsel, reg_req.wdata);

  // Channel activity
  wire [2:0] np = pairs_of(bs_q);
  wire stream_live = run_q[BIT_PAIR0] && !pause_q[BIT_PAIR0];
  logic [PAIRS-1:0] live, indep, need;
  always_comb begin
    for (int p = 0; p < PAIRS; p++) begin
      indep[p] = 3'(p) >= np;
      live[p] = indep[p] ? (run_q[pair_bit(p)] && !pause_q[pair_bit(p)]) : stream_live;
      need[p] = live[p] && lvl_q[p] <= REFILL_LEVEL;
    end
  end

  // Stream selection: interleaved first, then independent pairs by index
  wire sel_valid = need[0] || (need[1] && indep[1]) || (need[2] && indep[2]) || (need[3] && indep[3]);
  wire [1:0] sel_str = need[0] ? 2'd0 : (need[1] && indep[1]) ? 2'd1 : (need[2] && indep[2]) ? 2'd2 : 2'd3;
  wire [5:0] sel_len = (sel_str == 2'd0) ? {np, 3'b000} : 6'd8;

  // Burst position to FIFO cell
  wire [2:0] ntrk_last = (str_q == 2'd0) ? 3'({np, 1'b0} - 4'd1) : 3'd1;
  wire [2:0] wr_track = (str_q == 2'd0) ? trk_q : 3'({str_q, 1'b0} + {2'b00, trk_q});
  wire [1:0] wr_pair = wr_track[2:1];
  wire [3:0] wr_layer = wrap12({1'b0, wp_q[wr_pair]} + {3'b000, lay_q});
  wire last_word = trk_q == ntrk_last && lay_q == 2'd3;
  wire beat = state_q == ST_XFER && dma_dvalid;
  wire done = beat && last_word;
  wire ilv_beat = beat && str_q == 2'd0;

  logic [PAIRS-1:0] filled, drain, underrun;
  always_comb begin
    for (int p = 0; p < PAIRS; p++) begin
      filled[p] = done && ((str_q == 2'd0) ? !indep[p] : str_q == 2'(p));
      drain[p] = sample_tick && live[p] && lvl_q[p] != 4'h0;
      underrun[p] = sample_tick && live[p] && lvl_q[p] == 4'h0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (sel_valid) state_d = ST_REQ;
      ST_REQ: if (dma_gnt) state_d = ST_XFER;
      ST_XFER: if (done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Error flags: hardware set wins over a same-cycle clear
  logic [7:0] err_set;
  always_comb begin
    err_set = 8'h00;
    err_set[BIT_PAIR0] = underrun[0];
    err_set[BIT_PAIR1] = underrun[1] && indep[1];
    err_set[BIT_PAIR2] = underrun[2] && indep[2];
    err_set[BIT_PAIR3] = underrun[3] && indep[3];
    err_set[BIT_DOUT] = ext_err[2];
    err_set[BIT_REC1] = ext_err[1];
    err_set[BIT_REC0] = ext_err[0];
  end
  wire [7:0] flag_clr = wr_flags ? (reg_req.wdata & CHAN_WMASK) : 8'h00;
  wire [7:0] flags_d = (flags_q & ~flag_clr) | err_set;

  // Read mux
  logic [7:0] rd_d;
  always_comb begin
    case (reg_req.addr)
      OFF_IRQ_MASK: rd_d = mask_q;
      OFF_ADDR_B0: rd_d = {cur_addr_q[5:0], 2'b00};
      8'h11: rd_d = cur_addr_q[13:6];
      8'h12: rd_d = cur_addr_q[21:14];
      OFF_ADDR_B3: rd_d = cur_addr_q[29:22];
      OFF_CNT_B0: rd_d = cur_cnt_q[7:0];
      8'h15: rd_d = cur_cnt_q[15:8];
      OFF_CNT_B2: rd_d = {5'h0, cur_cnt_q[18:16]};
      OFF_RUN: rd_d = run_q;
      OFF_BURST: rd_d = {6'h0, bs_q};
      OFF_FLAGS: rd_d = flags_q;
      OFF_PAUSE: rd_d = pause_q;
      default: rd_d = 8'h00;
    endcase
  end

  // Output mapping per link mode
  logic [SAMPLE_W-1:0] head [TRACKS];
  always_comb begin
    for (int t = 0; t < TRACKS; t++)
      head[t] = (live[t/2] && lvl_q[t/2] != 4'h0) ? mem[rp_q[t/2]][t] : '0;
  end
  mcd_slots_t slots_d;
  always_comb begin
    slots_d = '0;
    slots_d.s3 = head[0];
    slots_d.s4 = head[1];
    if (aclink_packed) begin
      slots_d.s6 = head[2];
      slots_d.s9 = head[3];
      slots_d.s7 = head[4];
      slots_d.s8 = head[5];
      slots_d.s10 = head[6];
      slots_d.s11 = head[7];
    end
  end

  // Control and registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      run_q <= RUN_RST;
      pause_q <= PAUSE_RST;
      flags_q <= FLAGS_RST;
      mask_q <= MASK_RST;
      bs_q <= BURST_RST;
      reg_rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      state_q <= state_d;
      if (wr_run) run_q <= reg_req.wdata & CHAN_WMASK;
      if (wr_pause) pause_q <= reg_req.wdata & CHAN_WMASK;
      if (wr_bs) bs_q <= reg_req.wdata[1:0];
      if (wr_mask) mask_q <= reg_req.wdata;
      flags_q <= flags_d;
      if (reg_req.rd) reg_rdata <= rd_d;
      irq <= (|flags_q) && !mask_q[BIT_MASK_ERR];
    end
  end

  // Interleaved fetch address and count
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      base_addr_q <= ADDR_RST;
      cur_addr_q <= ADDR_RST;
      base_cnt_q <= CNT_RST;
      cur_cnt_q <= CNT_RST;
    end else if (wr_addr) begin
      base_addr_q <= addr_new[31:2];
      cur_addr_q <= addr_new[31:2];
    end else if (wr_cnt) begin
      base_cnt_q <= cnt_new[18:0];
      cur_cnt_q <= cnt_new[18:0];
    end else if (ilv_beat) begin
      if (cur_cnt_q == 19'h0) begin
        cur_cnt_q <= base_cnt_q;
        cur_addr_q <= base_addr_q;
      end else begin
        cur_cnt_q <= cur_cnt_q - 19'h1;
        cur_addr_q <= cur_addr_q + 30'h1;
      end
    end
  end

  // Burst bookkeeping; request held until granted
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dma_req <= '0;
      str_q <= 2'd0;
      trk_q <= 3'd0;
      lay_q <= 2'd0;
    end else begin
      if (state_q == ST_IDLE && sel_valid) begin
        dma_req.req <= 1'b1;
        dma_req.addr <= {cur_addr_q, 2'b00};
        dma_req.len <= sel_len;
        dma_req.stream <= sel_str;
        str_q <= sel_str;
        trk_q <= 3'd0;
        lay_q <= 2'd0;
      end else if (state_q == ST_REQ && dma_gnt) begin
        dma_req.req <= 1'b0;
      end
      if (beat) begin
        if (trk_q == ntrk_last) begin
          trk_q <= 3'd0;
          lay_q <= lay_q + 2'd1;
        end else begin
          trk_q <= trk_q + 3'd1;
        end
      end
    end
  end

  // Per-pair fill levels and pointers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      for (int p = 0; p < PAIRS; p++) begin
        lvl_q[p] <= 4'h0;
        wp_q[p] <= 4'h0;
        rp_q[p] <= 4'h0;
      end
    end else begin
      for (int p = 0; p < PAIRS; p++) begin
        lvl_q[p] <= lvl_q[p] + (filled[p] ? BURST_LAYERS : 4'h0) - (drain[p] ? 4'h1 : 4'h0);
        if (filled[p]) wp_q[p] <= wrap12({1'b0, wp_q[p]} + {1'b0, BURST_LAYERS});
        if (drain[p]) rp_q[p] <= wrap12({1'b0, rp_q[p]} + 5'd1);
      end
    end
  end

  // Sample store; top 24 bits of each word carry the sample
  always_ff @(posedge sys_clk) begin
    if (beat) mem[wr_layer][wr_track] <= dma_data[31:8];
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) slot_data <= '0;
    else if (sample_tick) slot_data <= slots_d;
  end
endmodule // mcd_playback_dma

// file: src/mcd_pkg.sv
package mcd_pkg;
  // FIFO geometry
  localparam int LAYERS = 12;
  localparam int TRACKS = 8;
  localparam int PAIRS = 4;
  localparam int SAMPLE_W = 24;
  localparam logic [3:0] BURST_LAYERS = 4'h4;
  localparam logic [3:0] REFILL_LEVEL = 4'h8;
  localparam logic [3:0] LAST_LAYER = 4'hb;
  // Register offsets (byte index on the register port)
  localparam logic [7:0] OFF_IRQ_MASK = 8'h03;
  localparam logic [7:0] OFF_ADDR_B0 = 8'h10;
  localparam logic [7:0] OFF_ADDR_B3 = 8'h13;
  localparam logic [7:0] OFF_CNT_B0 = 8'h14;
  localparam logic [7:0] OFF_CNT_B2 = 8'h16;
  localparam logic [7:0] OFF_RUN = 8'h18;
  localparam logic [7:0] OFF_BURST = 8'h19;
  localparam logic [7:0] OFF_FLAGS = 8'h1a;
  localparam logic [7:0] OFF_PAUSE = 8'h1b;
  // Channel bit positions shared by run, pause and flag registers; BIT_MASK_ERR is the mask register's error enable
  localparam int BIT_PAIR0 = 0;
  localparam int BIT_REC0 = 1;
  localparam int BIT_REC1 = 2;
  localparam int BIT_PAIR1 = 4;
  localparam int BIT_PAIR2 = 5;
  localparam int BIT_PAIR3 = 6;
  localparam int BIT_DOUT = 7;
  localparam int BIT_MASK_ERR = 3;
  localparam logic [7:0] CHAN_WMASK = 8'hf7;
  // Burst size codes
  localparam logic [1:0] BS_8CH = 2'h0;
  localparam logic [1:0] BS_6CH = 2'h1;
  localparam logic [1:0] BS_4CH = 2'h2;
  // Reset values
  localparam logic [7:0] RUN_RST = 8'h00;
  localparam logic [7:0] PAUSE_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [1:0] BURST_RST = 2'h0;
  localparam logic [29:0] ADDR_RST = 30'h0;
  localparam logic [18:0] CNT_RST = 19'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcd_reg_req_t;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [5:0] len;
    logic [1:0] stream;
  } mcd_dma_req_t;

  typedef struct packed {
    logic [23:0] s3;
    logic [23:0] s4;
    logic [23:0] s6;
    logic [23:0] s7;
    logic [23:0] s8;
    logic [23:0] s9;
    logic [23:0] s10;
    logic [23:0] s11;
  } mcd_slots_t;
endpackage

// file: tb/mcd_checker.sv
`timescale 1ns/100ps
module mcd_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Register port
  input wire mcd_pkg::mcd_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Bus master
  input wire mcd_pkg::mcd_dma_req_t dma_req,
  input wire logic dma_gnt,
  // Serial output side
  input wire logic sample_tick,
  input wire logic aclink_packed,
  input wire mcd_pkg::mcd_slots_t slot_data,
  input wire logic irq
);
  import mcd_pkg::*;
  logic [7:0] mask_q, run_q, pause_q;
  logic [1:0] bs_q;
  wire [5:0] len_exp = 6'h20 - {1'b0, bs_q, 3'h0};
  // Shadow copies of the registers the outputs depend on
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mask_q <= MASK_RST;
      run_q <= RUN_RST;
      pause_q <= PAUSE_RST;
      bs_q <= BURST_RST;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OFF_IRQ_MASK) mask_q <= reg_req.wdata;
      if (reg_req.addr == OFF_RUN) run_q <= reg_req.wdata;
      if (reg_req.addr == OFF_PAUSE) pause_q <= reg_req.wdata;
      if (reg_req.addr == OFF_BURST) bs_q <= reg_req.wdata[1:0];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_req_hold: assert property (dma_req.req && !dma_gnt |=> dma_req.req && $stable(dma_req))
    else $error("request dropped or changed before grant");
  chk_req_drop: assert property (dma_req.req && dma_gnt |=> !dma_req.req)
    else $error("request still high after grant");
  chk_len_code: assert property ($rose(dma_req.req) && dma_req.stream == 2'h0 |-> dma_req.len == len_exp)
    else $error("stream burst length does not match burst code");
  chk_pair_len: assert property (dma_req.req && dma_req.stream != 2'h0 |-> dma_req.len == 6'h08)
    else $error("pair burst length not eight");
  chk_addr_align: assert property (dma_req.req |-> dma_req.addr[1:0] == 2'h0)
    else $error("burst address not dword aligned");
  chk_irq_mask: assert property (irq |-> !$past(mask_q[BIT_MASK_ERR]))
    else $error("interrupt while masked");
  chk_req_run: assert property ($rose(dma_req.req) && dma_req.stream == 2'h0 |-> $past(run_q[0] && !pause_q[0]))
    else $error("stream request while stopped or paused");
  chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  chk_slot_hold: assert property (!sample_tick |=> $stable(slot_data))
    else $error("slots changed without a tick");
  chk_i2s_quiet: assert property (sample_tick && !aclink_packed |=> slot_data.s6 == 24'h0 && slot_data.s11 == 24'h0)
    else $error("extra slots driven in serial mode");
  cover property ($rose(irq));
  cover property (dma_req.req && dma_req.stream != 2'h0);
  cover property (sample_tick && aclink_packed);
endmodule // mcd_checker
bind mcd_playback_dma mcd_checker mcd_checker_i (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_gnt(dma_gnt), .sample_tick(sample_tick),
  .aclink_packed(aclink_packed), .slot_data(slot_data), .irq(irq));

// file: tb/mcd_host_mem.sv
`timescale 1ns/100ps
module mcd_host_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Bus side
  input wire mcd_pkg::mcd_dma_req_t dma_req,
  input wire logic stall,
  output logic dma_gnt,
  output logic dma_dvalid,
  output logic [31:0] dma_data
);
  import mcd_pkg::*;
  logic [5:0] left;
  logic [23:0] k;
  // Idle data toggles so a stale word never passes for a live one
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dma_gnt <= 1'b0;
      dma_dvalid <= 1'b0;
      left <= 6'h0;
      k <= 24'h0;
      dma_data <= 32'h0;
    end else begin
      dma_gnt <= dma_req.req && !dma_gnt && !stall && !dma_dvalid;
      if (dma_req.req && dma_gnt) begin
        dma_dvalid <= 1'b1;
        dma_data <= {dma_req.addr[23:0], 8'ha5};
        k <= 24'h1;
        left <= dma_req.len - 6'h1;
      end else if (left != 6'h0) begin
        dma_data <= {dma_req.addr[23:0] + k, 8'ha5};
        k <= k + 24'h1;
        left <= left - 6'h1;
      end else begin
        dma_dvalid <= 1'b0;
        dma_data <= ~dma_data;
      end
    end
  end
endmodule // mcd_host_mem

// file: tb/mcd_playback_dma_bench.sv
`timescale 1ns/100ps
module mcd_playback_dma_bench;
  import mcd_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  mcd_reg_req_t reg_req = '0;
  mcd_dma_req_t dma_req;
  mcd_slots_t slot_data;
  logic [7:0] reg_rdata;
  logic dma_gnt, dma_dvalid, irq;
  logic [31:0] dma_data;
  logic sample_tick = 1'b0;
  logic aclink_packed = 1'b0;
  logic stall = 1'b0;
  logic [2:0] ext_err = 3'h0;
  logic req_d = 1'b0;
  logic rd_pend = 1'b0;
  logic tick_pend = 1'b0;
  logic [7:0] rq[$];
  logic [23:0] sq[$];
  logic [29:0] base;
  logic [18:0] cnt;
  int err_total = 0;
  int checks_done = 0;
  int nreq = 0;
  always #2 sys_clk = ~sys_clk;
  mcd_playback_dma mcd_playback_dma_i (.sys_clk(sys_clk), .nrst(nrst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .dma_req(dma_req), .dma_gnt(dma_gnt), .dma_dvalid(dma_dvalid),
    .dma_data(dma_data), .sample_tick(sample_tick), .aclink_packed(aclink_packed),
    .ext_err(ext_err), .slot_data(slot_data), .irq(irq));
  mcd_host_mem mcd_host_mem_i (.sys_clk(sys_clk), .nrst(nrst), .dma_req(dma_req), .stall(stall),
    .dma_gnt(dma_gnt), .dma_dvalid(dma_dvalid), .dma_data(dma_data));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    rq.push_back(e);
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
  endtask
  task automatic wrn(input logic [7:0] a, input logic [31:0] v, input int n);
    for (int b = 0; b < n; b++) wr(a + 8'(b), v[8*b +: 8]);
  endtask
  task automatic rdn(input logic [7:0] a, input logic [31:0] v, input int n);
    for (int b = 0; b < n; b++) rd(a + 8'(b), v[8*b +: 8]);
  endtask
  task automatic tick(input int n, input logic pk);
    repeat (n) begin
      @(posedge sys_clk);
      sample_tick <= 1'b1;
      aclink_packed <= pk | 1'($urandom);
      @(posedge sys_clk);
      sample_tick <= 1'b0;
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Results are compared one edge after the strobe that asked for them
  always @(posedge sys_clk) begin
    if (rd_pend) check(reg_rdata, rq.pop_front(), "register read");
    if (tick_pend && sq.size() > 0) begin
      check(slot_data.s3, sq.pop_front(), "left slot");
      check(slot_data.s4, sq.pop_front(), "right slot");
      check(slot_data.s6, sq.pop_front(), "pair one left slot");
      check(slot_data.s9, sq.pop_front(), "pair one right slot");
    end
    rd_pend <= reg_req.rd;
    tick_pend <= sample_tick;
    req_d <= dma_req.req;
    if (dma_req.req && !req_d) nreq++;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(81));
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(OFF_IRQ_MASK, MASK_RST);
    rd(OFF_FLAGS, FLAGS_RST);
    rdn(OFF_ADDR_B0, 32'h0, 4);
    rd(8'h05, 8'h00);
    wr(OFF_PAUSE, 8'hff);
    wr(OFF_RUN, 8'hff);
    wr(OFF_BURST, 8'hff);
    rd(OFF_PAUSE, 8'hf7);
    rd(OFF_RUN, 8'hf7);
    rd(OFF_BURST, 8'h03);
    for (int c = 0; c < 4; c++) begin
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      base = 30'($urandom);
      cnt = 19'h400 + 19'($urandom % 1024);
      wrn(OFF_ADDR_B0, {base, 2'h3}, 4);
      wrn(OFF_CNT_B0, {13'h0, cnt}, 3);
      wr(OFF_BURST, 8'(c));
      wr(OFF_PAUSE, 8'h71);
      wr(OFF_RUN, 8'h71);
      nreq = 0;
      repeat (40) @(posedge sys_clk);
      check(32'(nreq), 32'h0, "requests while paused");
      rd(OFF_PAUSE, 8'h71);
      wr(OFF_PAUSE, 8'h00);
      repeat (400) @(posedge sys_clk);
      check(32'(nreq), 32'(3 * (c + 1)), "request count");
      rdn(OFF_ADDR_B0, {base + 30'(3 * (32 - 8 * c)), 2'h0}, 4);
      rdn(OFF_CNT_B0, {13'h0, cnt - 19'(3 * (32 - 8 * c))}, 3);
    end
    stall <= 1'b1;
    wr(OFF_IRQ_MASK, 8'hf7);
    sq.push_back({base, 2'h0});
    sq.push_back({base, 2'h0} + 24'h1);
    // Pair one fetched after three stream bursts of eight words
    sq.push_back(24'({base, 2'h0}) + 24'h60);
    sq.push_back(24'({base, 2'h0}) + 24'h61);
    tick(1, 1'b1);
    tick(12, 1'b0);
    rd(OFF_FLAGS, 8'h71);
    check(irq, 1'b1, "irq on underrun");
    @(posedge sys_clk);
    ext_err <= 3'h7;
    @(posedge sys_clk);
    ext_err <= 3'h0;
    rd(OFF_FLAGS, 8'hf7);
    wr(OFF_IRQ_MASK, 8'hff);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0, "irq while masked");
    wr(OFF_IRQ_MASK, 8'hf7);
    wr(OFF_FLAGS, 8'h01);
    rd(OFF_FLAGS, 8'hf6);
    wr(OFF_FLAGS, 8'hf6);
    rd(OFF_FLAGS, 8'h00);
    repeat (2) @(posedge sys_clk);
    check(irq, 1'b0, "irq after clear");
    report_and_stop();
  end
endmodule // mcd_playback_dma_bench
